/* File: rtl/psar_defines.svh */
// Purpose: Named constants for the status, identifier and advertisement register bank
// Assumes: Included by the bank module
// Notes:   Offsets are management register addresses, positions are bit indices
`ifndef PSAR_DEFINES_SVH
`define PSAR_DEFINES_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PSAR_REG_STATUS 5'h01
`define PSAR_REG_ID_HIGH 5'h02
`define PSAR_REG_ID_LOW 5'h03
`define PSAR_REG_ADVERT 5'h04

// ------------------------------------------------------------
// Status bit positions and constant upper ten bits
// ------------------------------------------------------------
`define PSAR_ST_AN_DONE 5
`define PSAR_ST_RFAULT 4
`define PSAR_ST_AN_ABLE 3
`define PSAR_ST_LINK 2
`define PSAR_ST_JABBER 1
`define PSAR_ST_EXT_CAP 0
`define PSAR_ST_UPPER 10'h1e1

// ------------------------------------------------------------
// Reset values and frame constants
// ------------------------------------------------------------
`define PSAR_SEL_RESET 5'h01
`define PSAR_PRE_LEN 6'h20
`define PSAR_OP_READ 2'h2
`define PSAR_OP_WRITE 2'h1
`define PSAR_ADDR_LAST 4'h9
`define PSAR_DATA_LAST 4'hf
`endif

/* File: rtl/psar_pkg.sv */
// Purpose: Types shared by the register bank and its users
// Assumes: psar_defines.svh holds the numeric constants
// Notes:   The advertisement struct layout follows the register bit order, msb first
package psar_pkg;
  // ------------------------------------------------------------
  // Frame receiver states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PSAR_IDLE = 3'h0,
    PSAR_START = 3'h1,
    PSAR_OPCODE = 3'h2,
    PSAR_ADDR = 3'h3,
    PSAR_TURN = 3'h4,
    PSAR_DATA = 3'h5
  } psar_state_e;

  // Advertisement register image, one field per bit group
  typedef struct packed {
    logic next_page;
    logic rsvd14;
    logic remote_fault;
    logic rsvd12;
    logic asym_pause;
    logic pause;
    logic t4;
    logic [3:0] ability;
    logic [4:0] selector;
  } psar_adv_s;

  // Status inputs from the negotiation and link logic
  typedef struct packed {
    logic an_enable;
    logic an_complete;
    logic link_up;
    logic speed_10;
    logic jabber;
    logic far_end_fault;
    logic partner_fault;
  } psar_stat_s;
endpackage : psar_pkg

/* File: rtl/psar_regs.sv */
// Purpose: Status, identifier and advertisement registers behind the management pins
// Assumes: Management clock is far slower than clk and arrives from outside
// Notes:   Writes to other addresses are ignored, reads of them leave the pin released
`timescale 1ns/1ns
`include "psar_defines.svh"

// What this block does
// - Status bit 5 shows negotiation finished
// - Remote fault latches high until read
// - Far-end or partner fault sets remote fault
// - Link bit latches low after link loss
// - Later read while linked returns one
// - Jabber latches high, only in 10 Mbps
// - Status bit 3 constant one
// - Status bit 0 constant one
// - Model number in identifier bits 9:4
// - Revision number in identifier bits 3:0
// - Next-page bit writable, resets zero
// - Remote-fault advertise bit writable, resets zero
// - Asymmetric pause bit writable, resets zero
// - Symmetric pause bit writable, resets zero
// - T4 advertise bit stays zero
// - Ability bits writable, reset from straps
// - Selector writable, resets to 00001
// - Preamble only needed once or after errors
module psar_regs #(
  parameter logic [21:0] OUI = 22'h0a5a5a, // Arbitrary value
  parameter logic [5:0] MODEL = 6'h15, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Straps, caught while reset is high
  input wire logic [4:0] strap_phy_addr,
  input wire logic [3:0] strap_ability,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Negotiation side
  input wire psar_pkg::psar_stat_s stat_in,
  output psar_pkg::psar_adv_s adv_out
);
  import psar_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic mdc_s1_q; // First stage, read only by the second
  logic mdc_s2_q; // Usable clock level
  logic mdc_s3_q; // Previous level for edge detect
  logic mdio_s1_q; // First stage of data pin
  logic mdio_s2_q; // Usable data level

  // Two stages before any logic reads a pin
  always_ff @(posedge clk) begin
    if (reset) begin
      mdc_s1_q <= 1'b1; // Idle level, so leaving reset makes no false edge
      mdc_s2_q <= 1'b1;
      mdc_s3_q <= 1'b1;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q <= mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  logic rise; // One clk pulse per management clock rising edge
  logic bit_in; // Data bit sampled on that edge
  assign rise = mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;

  // ------------------------------------------------------------
  // Frame receiver state
  // ------------------------------------------------------------
  psar_state_e state_q; // Receiver state
  logic [5:0] ones_q; // Run of preamble ones, saturating
  logic pre_ok_q; // A full preamble has been seen
  logic [1:0] op_q; // Opcode shift
  logic [9:0] addr_q; // Device and register address shift
  logic [3:0] cnt_q; // Bit counter within a field
  logic [15:0] data_q; // Read shift out or write shift in
  logic [4:0] phy_addr_q; // Strapped device address
  logic [9:0] next_addr; // Address including the current bit
  logic addr_hit; // Frame is for this device
  logic mapped; // Register lives in this bank
  logic rd_load; // Read of a mapped register accepted
  logic status_rd; // That read targets the status register
  logic adv_commit; // Write to the advertisement register lands
  logic op_bad; // Opcode neither read nor write
  logic turn_bad; // Write turnaround not one then zero
  logic [15:0] rd_word; // Value of the addressed register

  assign next_addr = {addr_q[8:0], bit_in};
  assign addr_hit = (next_addr[9:5] == phy_addr_q);
  assign mapped = (next_addr[4:0] == `PSAR_REG_STATUS) || (next_addr[4:0] == `PSAR_REG_ID_HIGH)
    || (next_addr[4:0] == `PSAR_REG_ID_LOW) || (next_addr[4:0] == `PSAR_REG_ADVERT);
  assign rd_load = rise && (state_q == PSAR_ADDR) && (cnt_q == `PSAR_ADDR_LAST)
    && (op_q == `PSAR_OP_READ) && addr_hit && mapped;
  assign status_rd = rd_load && (next_addr[4:0] == `PSAR_REG_STATUS);
  assign adv_commit = rise && (state_q == PSAR_DATA) && (cnt_q == `PSAR_DATA_LAST)
    && (op_q == `PSAR_OP_WRITE) && (addr_q[9:5] == phy_addr_q)
    && (addr_q[4:0] == `PSAR_REG_ADVERT);
  assign op_bad = rise && (state_q == PSAR_OPCODE) && (cnt_q[0] == 1'b1)
    && ({op_q[0], bit_in} != `PSAR_OP_READ) && ({op_q[0], bit_in} != `PSAR_OP_WRITE);
  assign turn_bad = rise && (state_q == PSAR_TURN) && (op_q == `PSAR_OP_WRITE)
    && (bit_in != ~cnt_q[0]);

  // Straps are caught while reset is held, never after
  always_ff @(posedge clk) begin
    if (reset) begin
      phy_addr_q <= strap_phy_addr;
    end
  end

  // ------------------------------------------------------------
  // Frame sequencing, advanced on each management clock rising edge
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PSAR_IDLE;
      ones_q <= 6'h00;
      pre_ok_q <= 1'b0;
      op_q <= 2'h0;
      addr_q <= 10'h000;
      cnt_q <= 4'h0;
    end else if (rise) begin
      unique case (state_q)
        PSAR_IDLE: begin
          if (bit_in) begin
            // Saturate so a long preamble never wraps
            if (ones_q != `PSAR_PRE_LEN) ones_q <= ones_q + 6'h01;
            if (ones_q >= `PSAR_PRE_LEN - 6'h01) pre_ok_q <= 1'b1;
          end else begin
            // A zero starts a frame once any full preamble was seen
            ones_q <= 6'h00;
            if (pre_ok_q) state_q <= PSAR_START;
          end
        end
        PSAR_START: begin
          cnt_q <= 4'h0;
          state_q <= bit_in ? PSAR_OPCODE : PSAR_IDLE;
        end
        PSAR_OPCODE: begin
          op_q <= {op_q[0], bit_in};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q[0]) begin
            cnt_q <= 4'h0;
            if (op_bad) begin
              // Bad opcode demands a fresh full preamble
              pre_ok_q <= 1'b0;
              state_q <= PSAR_IDLE;
            end else begin
              state_q <= PSAR_ADDR;
            end
          end
        end
        PSAR_ADDR: begin
          addr_q <= next_addr;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PSAR_ADDR_LAST) begin
            cnt_q <= 4'h0;
            state_q <= PSAR_TURN;
          end
        end
        PSAR_TURN: begin
          cnt_q <= cnt_q + 4'h1;
          if (turn_bad) begin
            // Bad write turnaround also drops preamble credit
            pre_ok_q <= 1'b0;
            state_q <= PSAR_IDLE;
          end else if (cnt_q[0]) begin
            cnt_q <= 4'h0;
            state_q <= PSAR_DATA;
          end
        end
        PSAR_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PSAR_DATA_LAST) begin
            cnt_q <= 4'h0;
            ones_q <= 6'h00;
            state_q <= PSAR_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read and write data path, pin drive
  // ------------------------------------------------------------
  logic drive_q; // This frame is a read answered here

  // Shift data; drive turnaround zero then sixteen bits msb first
  always_ff @(posedge clk) begin
    if (reset) begin
      data_q <= 16'h0000;
      drive_q <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
    end else if (rd_load) begin
      // Snapshot taken at the address, so later events wait for the next read
      data_q <= rd_word;
      drive_q <= 1'b1;
    end else if (rise) begin
      if (state_q == PSAR_TURN && drive_q) begin
        if (!cnt_q[0]) begin
          mdio_oe <= 1'b1;
          mdio_out <= 1'b0;
        end else begin
          mdio_out <= data_q[15];
          data_q <= {data_q[14:0], 1'b0};
        end
      end else if (state_q == PSAR_DATA) begin
        if (drive_q) begin
          mdio_out <= data_q[15];
          data_q <= {data_q[14:0], 1'b0};
          if (cnt_q == `PSAR_DATA_LAST) begin
            // Release the pin after the last bit period
            mdio_oe <= 1'b0;
            mdio_out <= 1'b1;
            drive_q <= 1'b0;
          end
        end else begin
          data_q <= {data_q[14:0], bit_in};
        end
      end else if (state_q == PSAR_IDLE) begin
        drive_q <= 1'b0;
        mdio_oe <= 1'b0;
        mdio_out <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Latched status bits
  // ------------------------------------------------------------
  logic rfault_q; // Remote fault, latched high
  logic jabber_q; // Jabber, latched high
  logic link_q; // Link, latched low
  logic rfault_evt; // Either fault source this cycle
  logic jabber_evt; // Jabber while running at 10 Mbps

  assign rfault_evt = stat_in.far_end_fault | stat_in.partner_fault;
  assign jabber_evt = stat_in.jabber & stat_in.speed_10;

  // An event in the read cycle wins over the clear, so none is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      rfault_q <= 1'b0;
      jabber_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      if (rfault_evt) rfault_q <= 1'b1;
      else if (status_rd) rfault_q <= 1'b0;
      if (jabber_evt) jabber_q <= 1'b1;
      else if (status_rd) jabber_q <= 1'b0;
      // Link loss forces zero; only a read lets it rise again
      if (!stat_in.link_up) link_q <= 1'b0;
      else if (status_rd) link_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    unique case (next_addr[4:0])
      `PSAR_REG_STATUS: begin
        rd_word = {`PSAR_ST_UPPER, 6'h00};
        rd_word[`PSAR_ST_AN_DONE] = stat_in.an_enable & stat_in.an_complete;
        rd_word[`PSAR_ST_RFAULT] = rfault_q;
        rd_word[`PSAR_ST_AN_ABLE] = 1'b1;
        rd_word[`PSAR_ST_LINK] = link_q;
        rd_word[`PSAR_ST_JABBER] = jabber_q;
        rd_word[`PSAR_ST_EXT_CAP] = 1'b1;
      end
      `PSAR_REG_ID_HIGH: rd_word = OUI[21:6];
      `PSAR_REG_ID_LOW: rd_word = {OUI[5:0], MODEL, REVISION};
      `PSAR_REG_ADVERT: rd_word = adv_out;
      default: rd_word = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // Advertisement register
  // ------------------------------------------------------------
  psar_adv_s wr_adv; // Incoming write, including the last bit
  assign wr_adv = {data_q[14:0], bit_in};

  // Read-only bits stay zero whatever is written
  always_ff @(posedge clk) begin
    if (reset) begin
      adv_out <= '0;
      adv_out.ability <= strap_ability;
      adv_out.selector <= `PSAR_SEL_RESET;
    end else if (adv_commit) begin
      adv_out.next_page <= wr_adv.next_page;
      adv_out.remote_fault <= wr_adv.remote_fault;
      adv_out.asym_pause <= wr_adv.asym_pause;
      adv_out.pause <= wr_adv.pause;
      adv_out.ability <= wr_adv.ability;
      adv_out.selector <= wr_adv.selector;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_an_done_bit:
    assert property (status_rd |=> data_q[`PSAR_ST_AN_DONE]
      == $past(stat_in.an_enable & stat_in.an_complete)) else $error("an done bit wrong");
  a_fault_set:
    assert property (rfault_evt |=> rfault_q) else $error("remote fault not latched");
  a_fault_hold:
    assert property (rfault_q && !status_rd |=> rfault_q) else $error("remote fault lost");
  a_link_low:
    assert property (!stat_in.link_up |=> !link_q) else $error("link not latched low");
  a_link_read:
    assert property (status_rd |=> link_q == $past(stat_in.link_up)) else $error("link read");
  a_jabber_set:
    assert property (jabber_evt |=> jabber_q ##1 (jabber_q || $past(status_rd)))
      else $error("jabber not latched");
  a_const_bits:
    assert property (status_rd |=> data_q[`PSAR_ST_AN_ABLE] && data_q[`PSAR_ST_EXT_CAP])
      else $error("constant status bits wrong");
  a_id_low_word:
    assert property (rd_load && next_addr[4:0] == `PSAR_REG_ID_LOW
      |=> data_q == {OUI[5:0], MODEL, REVISION}) else $error("identifier word wrong");
  a_adv_rsvd:
    assert property (!adv_out.rsvd14 && !adv_out.rsvd12 && !adv_out.t4)
      else $error("read-only advertise bit set");
  a_adv_write:
    assert property (adv_commit |=> adv_out == ($past(wr_adv) & 16'hadff))
      else $error("advertise write wrong");
  a_pre_drop:
    assert property (op_bad || turn_bad |=> !pre_ok_q [*3]) else $error("preamble credit kept");
  c_status_read: cover property (status_rd ##[1:300] (state_q == PSAR_IDLE));
  c_adv_write: cover property (adv_commit);
  c_no_preamble: cover property (pre_ok_q && state_q == PSAR_DATA ##[1:300] rd_load);
endmodule : psar_regs

/* File: bench/psar_host.sv */
// Purpose: Behavioural management host that sends frames on the serial pins
// Assumes: The data pin has a pull-up, the device samples on the clock rise
// Notes:   The management clock stands high between frames
`timescale 1ns/1ns
module psar_host (
  // Resolved pin level
  input wire logic mdio_wire,
  // Host pin drive
  output logic mdc,
  output logic host_out,
  output logic host_oe
);
  localparam int HALF = 160; // Half of the 320 ns management period
  logic smp; // Pin level caught at the last rise

  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    mdc = 1'b1;
    host_out = 1'b1;
    host_oe = 1'b0;
    smp = 1'b1;
  end

  // One bit period: data changes while low, the pin is sampled at the rise
  task automatic bit_cell(input logic d, input logic drv);
    host_oe = drv;
    host_out = drv ? d : ~host_out; // A released drive never keeps its old value
    mdc = 1'b0;
    #(HALF);
    mdc = 1'b1;
    smp = mdio_wire;
    #(HALF);
  endtask : bit_cell

  // Whole frame; the offset keeps pin edges away from the system clock edges
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, input logic [1:0] ta, input int pre,
                      output logic [15:0] rd);
    logic [13:0] head;
    head = {2'b01, op, pa, ra};
    rd = 16'hffff;
    #7;
    for (int i = 0; i < pre; i++) bit_cell(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_cell(head[i], 1'b1);
    if (op == 2'b10) begin
      // Read: let go for the turnaround and take the device's bits
      bit_cell(1'b1, 1'b0);
      bit_cell(1'b1, 1'b0);
      for (int i = 15; i >= 0; i--) begin
        bit_cell(1'b1, 1'b0);
        rd[i] = smp;
      end
      #(HALF); // Give the device time to release before the next drive
    end else begin
      // Write or refused frame: host drives the caller's turnaround and data
      bit_cell(ta[1], 1'b1);
      bit_cell(ta[0], 1'b1);
      for (int i = 15; i >= 0; i--) bit_cell(wd[i], 1'b1);
    end
    host_oe = 1'b0;
  endtask : xfer
endmodule : psar_host

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the status, identifier and advertisement bank
// Assumes: The host model drives the management pins, the pin is pulled up
// Notes:   Straps and write data are random from a fixed seed
`timescale 1ns/1ns
module tb_top;
  import psar_pkg::*;
  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  localparam logic [21:0] OUI = 22'h1b3c4d; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h2a; // Arbitrary value
  localparam logic [3:0] REVISION = 4'h6; // Arbitrary value
  localparam logic [15:0] ADV_MASK = 16'hadff; // Bits 14, 12 and 9 never set
  // Per status step: toggle kept, two-cycle pulse, expected bits 5:0
  localparam logic [6:0] TM [12] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
                                     7'h00, 7'h00, 7'h08, 7'h00, 7'h20, 7'h60};
  localparam logic [6:0] PM [12] = '{7'h00, 7'h00, 7'h10, 7'h00, 7'h02, 7'h00,
                                     7'h01, 7'h04, 7'h04, 7'h00, 7'h00, 7'h00};
  localparam logic [5:0] EX [12] = '{6'h29, 6'h2d, 6'h29, 6'h2d, 6'h3d, 6'h2d,
                                     6'h3d, 6'h2d, 6'h2f, 6'h2d, 6'h0d, 6'h0d};
  logic clk; // System clock
  logic reset; // Synchronous reset
  logic [4:0] phy; // Device address strap
  logic [3:0] strap; // Ability reset strap
  logic mdc; // Management clock from the host
  logic mdio_wire; // Resolved data pin
  logic host_out; // Host data drive
  logic host_oe; // Host drive enable
  logic dev_out; // Device data drive
  logic dev_oe; // Device drive enable
  psar_stat_s stat; // Negotiation and link status levels
  psar_adv_s adv; // Advertisement image
  int miscompares = 0; // Mismatch count
  int comparisons = 0; // Compare count
  int cyc = 0; // Cycle count for the timeout
  logic [15:0] v; // Last read word
  logic [15:0] wd; // Last written word

  // Pin level: device first, then host, else the pull-up
  assign mdio_wire = dev_oe ? dev_out : (host_oe ? host_out : 1'b1);

  psar_regs #(.OUI(OUI), .MODEL(MODEL), .REVISION(REVISION)) psar_regs_inst (
    .clk(clk), .reset(reset), .strap_phy_addr(phy), .strap_ability(strap),
    .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(dev_out), .mdio_oe(dev_oe),
    .stat_in(stat), .adv_out(adv)
  );

  psar_host psar_host_inst (
    .mdio_wire(mdio_wire), .mdc(mdc), .host_out(host_out), .host_oe(host_oe)
  );

  // ------------------------------------------------------------
  // Clock and timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // About 40 frames take near 11000 cycles, so this ceiling means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      $display("ERROR timeout expected finish seen hang");
      results();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Register read at the strapped address
  task automatic rd(input logic [4:0] ra, input int pre, output logic [15:0] r);
    psar_host_inst.xfer(2'b10, phy, ra, 16'h0000, 2'b10, pre, r);
  endtask : rd

  task automatic results();
    $display("compares %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hee6fd584));
    stat = psar_stat_s'(7'h70); // Negotiation on and done, link up, 100 Mbps
    phy = 5'($urandom);
    strap = 4'($urandom);
    reset = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    repeat (4) @(negedge clk);
    // Reset image, first frame carries the full preamble
    check("adv_out reset", adv, {7'h00, strap, 5'h01});
    rd(5'h04, 32, v);
    check("advert reset read", v, {7'h00, strap, 5'h01});
    $display("test reset values done");
    // Identifier words; a write to the high word must not stick
    psar_host_inst.xfer(2'b01, phy, 5'h02, 16'h5a5a, 2'b10, 0, v);
    rd(5'h02, 0, v);
    check("identifier high", v, OUI[21:6]);
    rd(5'h03, 0, v);
    check("identifier low", v, {OUI[5:0], MODEL, REVISION});
    $display("test identifiers done");
    // Status latches: link drop, both fault sources, jabber by speed, completion
    for (int i = 0; i < 12; i++) begin
      @(negedge clk) stat = psar_stat_s'(stat ^ TM[i]);
      @(negedge clk) stat = psar_stat_s'(stat ^ PM[i]);
      repeat (2) @(negedge clk);
      stat = psar_stat_s'(stat ^ PM[i]);
      repeat (2) @(negedge clk);
      rd(5'h01, 0, v);
      check("status word", v, {10'h1e1, EX[i]});
    end
    $display("test status done");
    // Advertisement writes: all ones, all zeros, then random words
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($urandom));
      psar_host_inst.xfer(2'b01, phy, 5'h04, wd, 2'b10, 0, v);
      @(negedge clk);
      check("adv_out", adv, wd & ADV_MASK);
      rd(5'h04, 0, v);
      check("advert read", v, wd & ADV_MASK);
    end
    $display("test advertisement done");
    // A bad opcode forces a fresh preamble before the next frame is taken
    psar_host_inst.xfer(2'b11, phy, 5'h04, 16'h0000, 2'b10, 0, v);
    rd(5'h04, 0, v);
    check("read without preamble", v, 16'hffff);
    rd(5'h04, 32, v);
    check("read after preamble", v, wd & ADV_MASK);
    // A bad write turnaround drops the frame and the preamble credit as well
    psar_host_inst.xfer(2'b01, phy, 5'h04, 16'h0000, 2'b11, 0, v);
    @(negedge clk);
    check("adv_out after bad turnaround", adv, wd & ADV_MASK);
    rd(5'h04, 0, v);
    check("read after bad turnaround", v, 16'hffff);
    rd(5'h04, 32, v);
    check("advert kept", v, wd & ADV_MASK);
    $display("test preamble done");
    results();
  end
endmodule : tb_top
